//--- core/ulfc_core.sv
// Line format, trigger level and modem control for one UART channel.
// Assumes FIFO counts and the transmit bit stream on the same clock,
// modem and receive pins asynchronous, AHB-Lite master on the bus.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
module ulfc_core (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // FIFO and serial engine side
   input  wire logic [5:0]  rx_count_i,
   input  wire logic [5:0]  tx_count_i,
   input  wire logic        tx_serial_i,
   input  wire logic        auto_rts_n_i,
   output ulfc_pkg::ulfc_fmt_t fmt_o,
   output logic      [15:0] divisor_o,
   output logic             fifo_en_o,
   output logic             dma_mode_o,
   output logic             rx_fifo_clr_o,
   output logic             tx_fifo_clr_o,
   output logic      [5:0]  rx_level_o,
   output logic      [5:0]  tx_level_o,
   output logic             rx_data_o,
   output logic             loopback_o,
   output logic             irda_en_o,
   // Pins
   input  wire logic        rx_pin_i,
   input  wire logic        cts_n_i,
   input  wire logic        dsr_n_i,
   input  wire logic        ring_indicator_in_n_i,
   input  wire logic        cd_n_i,
   output logic             tx_pin_o,
   output logic             dtr_n_o,
   output logic             rts_n_o,
   output logic             out2_n_o,
   output logic             irq_o
);
   import ulfc_pkg::*;

   ulfc_bus_t   state_r;
   ulfc_aph_t   aph_r;
   logic [7:0]  line_r;
   logic [7:0]  modem_r;
   logic [7:0]  feat_r;
   logic [3:0]  delta_r;
   logic [3:0]  mhi_prev_r;
   logic [3:0]  istat_r;
   logic [3:0]  imask_r;
   logic        wr, rd, enh, loop, irda;
   logic        rx_s, cts_s, dsr_s, ri_s, cd_s;
   logic        rx_up, tx_down, tx_empty;
   logic [3:0]  mhi;
   logic [3:0]  delta_new;
   logic [3:0]  ev;
   logic [31:0] rd_mux;
   ulfc_fmt_t   fmt_nxt;

   assign wr   = (state_r == BUS_WR) && aph_r.hit;
   assign rd   = (state_r == BUS_RD) && aph_r.hit;
   assign enh  = feat_r[EF_ENH];
   assign loop = modem_r[MC_LOOP];
   assign irda = modem_r[MC_IR] && enh;
   // Pin synchronisers
   ulfc_sync #(.INIT(1'b1)) u_rx (.clk_i(clk_i), .nrst_i(nrst_i),
      .pin_i(rx_pin_i), .level_o(rx_s));
   ulfc_sync #(.INIT(1'b1)) u_cts (.clk_i(clk_i), .nrst_i(nrst_i),
      .pin_i(cts_n_i), .level_o(cts_s));
   ulfc_sync #(.INIT(1'b1)) u_dsr (.clk_i(clk_i), .nrst_i(nrst_i),
      .pin_i(dsr_n_i), .level_o(dsr_s));
   ulfc_sync #(.INIT(1'b1)) u_ri (.clk_i(clk_i), .nrst_i(nrst_i),
      .pin_i(ring_indicator_in_n_i), .level_o(ri_s));
   ulfc_sync #(.INIT(1'b1)) u_cd (.clk_i(clk_i), .nrst_i(nrst_i),
      .pin_i(cd_n_i), .level_o(cd_s));
   // Fill level watchers
   ulfc_trig u_rxt (.clk_i(clk_i), .nrst_i(nrst_i), .count_i(rx_count_i),
      .level_i(rx_level_o), .up_o(rx_up), .down_o(), .empty_o());
   ulfc_trig u_txt (.clk_i(clk_i), .nrst_i(nrst_i), .count_i(tx_count_i),
      .level_i(tx_level_o), .up_o(), .down_o(tx_down), .empty_o(tx_empty));
   // Bus slave: writes zero wait, reads one wait state
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r     <= BUS_IDLE;
         aph_r       <= '0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0; // Always OKAY
      end else begin
         unique case (state_r)
            BUS_IDLE, BUS_WR: begin
               if (hready_i && hsel_i && htrans_i[1]) begin
                  aph_r.hit   <= (haddr_i[31:8] == 24'h00_0000);
                  aph_r.addr  <= haddr_i[7:0];
                  state_r     <= hwrite_i ? BUS_WR : BUS_RD;
                  hreadyout_o <= hwrite_i;
               end else begin
                  state_r <= BUS_IDLE;
               end
            end
            BUS_RD: begin
               state_r     <= BUS_IDLE;
               hreadyout_o <= 1'b1;
            end
         endcase
      end
   end

   // Read mux, unmapped and write-only offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (aph_r.addr)
         A_LINE:  rd_mux[7:0] = line_r;
         A_MODEM: rd_mux[7:0] = modem_r;
         A_FEAT:  rd_mux[7:0] = feat_r;
         A_MSTAT: rd_mux[7:0] = {mhi, delta_r};
         A_DIVL:  rd_mux[7:0] = line_r[LC_DLAB] ? divisor_o[7:0] : 8'h00;
         A_DIVH:  rd_mux[7:0] = line_r[LC_DLAB] ? divisor_o[15:8] : 8'h00;
         A_ISTAT: rd_mux[3:0] = istat_r;
         A_IMASK: rd_mux[3:0] = imask_r;
         A_LEVEL: rd_mux[13:0] = {fifo_en_o, dma_mode_o,
                                  tx_level_o, rx_level_o};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data capture
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (state_r == BUS_RD) begin
         hrdata_o <= aph_r.hit ? rd_mux : 32'h0000_0000;
      end
   end
   // FIFO control write; other bits need the enable bit in the same write
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fifo_en_o     <= 1'b0;
         dma_mode_o    <= 1'b0;
         rx_level_o    <= LVL_RESET;
         tx_level_o    <= LVL_RESET;
         rx_fifo_clr_o <= 1'b0;
         tx_fifo_clr_o <= 1'b0;
      end else begin
         rx_fifo_clr_o <= 1'b0;
         tx_fifo_clr_o <= 1'b0;
         if (wr && aph_r.addr == A_FIFO) begin
            fifo_en_o <= hwdata_i[FC_EN];
            if (hwdata_i[FC_EN]) begin
               dma_mode_o    <= hwdata_i[FC_DMA];
               rx_fifo_clr_o <= hwdata_i[FC_RXCLR];
               tx_fifo_clr_o <= hwdata_i[FC_TXCLR];
               rx_level_o <= RX_LVL_TAB[hwdata_i[FC_RXSEL +: 2] * 6 +: 6];
               if (enh) begin
                  tx_level_o <= TX_LVL_TAB[hwdata_i[FC_TXSEL +: 2] * 6 +: 6];
               end
            end
         end
      end
   end

   // Line control register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         line_r <= LINE_RESET;
      end else if (wr && aph_r.addr == A_LINE) begin
         line_r <= hwdata_i[7:0];
      end
   end

   // Modem control register; upper bits need enhanced mode
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         modem_r <= MODEM_RESET;
      end else if (wr && aph_r.addr == A_MODEM) begin
         modem_r[4:0] <= hwdata_i[4:0];
         if (enh) begin
            modem_r[7:5] <= hwdata_i[7:5];
         end
      end
   end

   // Enhanced feature register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         feat_r <= FEAT_RESET;
      end else if (wr && aph_r.addr == A_FEAT) begin
         feat_r <= hwdata_i[7:0];
      end
   end

   // Divisor latch
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         divisor_o <= DIV_RESET;
      end else if (wr && line_r[LC_DLAB]) begin
         if (aph_r.addr == A_DIVL) begin
            divisor_o[7:0] <= hwdata_i[7:0];
         end
         if (aph_r.addr == A_DIVH) begin
            divisor_o[15:8] <= hwdata_i[7:0];
         end
      end
   end

   // Character format decode
   always_comb begin
      fmt_nxt = '0;
      fmt_nxt.char_bits = CHAR_BASE + {2'b00, line_r[1:0]};
      if (!line_r[LC_STOP]) begin
         fmt_nxt.stop_halves = STOP_ONE;
      end else if (line_r[1:0] == 2'b00) begin
         fmt_nxt.stop_halves = STOP_ONEH;
      end else begin
         fmt_nxt.stop_halves = STOP_TWO;
      end
      fmt_nxt.par_en = line_r[LC_PEN];
      fmt_nxt.par_even = line_r[LC_PEN] && line_r[LC_EVEN];
      fmt_nxt.par_force = line_r[LC_PEN] && line_r[LC_FORCE];
      fmt_nxt.par_bit = !line_r[LC_EVEN];
      fmt_nxt.brk = line_r[LC_BRK];
   end
   // Format register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fmt_o <= '0;
      end else begin
         fmt_o <= fmt_nxt;
      end
   end

   // Serial and modem outputs
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_pin_o   <= 1'b1;
         dtr_n_o    <= 1'b1;
         rts_n_o    <= 1'b1;
         out2_n_o   <= 1'b1;
         rx_data_o  <= 1'b1;
         loopback_o <= 1'b0;
         irda_en_o  <= 1'b0;
      end else begin
         if (line_r[LC_BRK]) begin
            tx_pin_o <= 1'b0;
         end else begin
            tx_pin_o <= loop ? 1'b1 : tx_serial_i;
         end
         dtr_n_o <= ~modem_r[MC_DTR];
         rts_n_o  <= feat_r[EF_ARTS] ? auto_rts_n_i : ~modem_r[MC_RTS];
         out2_n_o <= ~modem_r[MC_OUT2];
         if (loop) begin
            rx_data_o <= tx_serial_i;
         end else if (irda && !modem_r[MC_IRPOL]) begin
            rx_data_o <= ~rx_s;
         end else begin
            rx_data_o <= rx_s;
         end
         loopback_o <= loop;
         irda_en_o  <= irda;
      end
   end
   // Modem status: bits 7:4 are CD, RI, DSR, CTS
   always_comb begin
      if (loop) begin
         mhi = {modem_r[MC_OUT2], modem_r[MC_IRPOL],
                modem_r[MC_DTR], modem_r[MC_RTS]};
      end else begin
         mhi = ~{cd_s, ri_s, dsr_s, cts_s};
      end
      delta_new    = mhi ^ mhi_prev_r;
      // Ring delta only at end of ringing
      delta_new[2] = mhi_prev_r[2] && !mhi[2];
   end

   // Delta flags; a new change wins over the read clear
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mhi_prev_r <= 4'h0;
         delta_r    <= 4'h0;
      end else begin
         mhi_prev_r <= mhi;
         if (rd && aph_r.addr == A_MSTAT) begin
            delta_r <= delta_new;
         end else begin
            delta_r <= delta_r | delta_new;
         end
      end
   end
   // Interrupt events, wake bit unused
   // bit 0 receive level crossed, bit 1 transmit level crossed or emptied, bit 2 modem status change
   assign ev = {1'b0, |delta_new, tx_down || tx_empty, rx_up};

   // Sticky status, write one to clear, set wins
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         istat_r <= 4'h0;
      end else if (wr && aph_r.addr == A_ISTAT) begin
         istat_r <= (istat_r & ~hwdata_i[3:0]) | ev;
      end else begin
         istat_r <= istat_r | ev;
      end
   end
   // Interrupt mask
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         imask_r <= 4'h0;
      end else if (wr && aph_r.addr == A_IMASK) begin
         imask_r <= hwdata_i[3:0];
      end
   end
   // Interrupt output
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(istat_r & imask_r);
      end
   end

endmodule : ulfc_core

//--- core/ulfc_pkg.sv
// Shared constants and types for the line format control block.
// Assumes a single 50 MHz clock and an AHB-Lite register port.
package ulfc_pkg;

   // Register byte offsets
   localparam logic [7:0] A_FIFO  = 8'h00;
   localparam logic [7:0] A_LINE  = 8'h04;
   localparam logic [7:0] A_MODEM = 8'h08;
   localparam logic [7:0] A_FEAT  = 8'h0C;
   localparam logic [7:0] A_MSTAT = 8'h10;
   localparam logic [7:0] A_DIVL  = 8'h14;
   localparam logic [7:0] A_DIVH  = 8'h18;
   localparam logic [7:0] A_ISTAT = 8'h1C;
   localparam logic [7:0] A_IMASK = 8'h20;
   localparam logic [7:0] A_LEVEL = 8'h24;

   // fifo_control fields
   localparam int FC_EN    = 0;
   localparam int FC_RXCLR = 1;
   localparam int FC_TXCLR = 2;
   localparam int FC_DMA   = 3;
   localparam int FC_TXSEL = 4;
   localparam int FC_RXSEL = 6;

   // line_control fields
   localparam int LC_STOP  = 2;
   localparam int LC_PEN   = 3;
   localparam int LC_EVEN  = 4;
   localparam int LC_FORCE = 5;
   localparam int LC_BRK   = 6;
   localparam int LC_DLAB  = 7;

   // modem_control fields
   localparam int MC_DTR   = 0;
   localparam int MC_RTS   = 1;
   localparam int MC_IRPOL = 2;
   localparam int MC_OUT2  = 3;
   localparam int MC_LOOP  = 4;
   localparam int MC_IR    = 6;

   // enhanced_feature_register fields
   localparam int EF_ENH   = 4;
   localparam int EF_ARTS  = 6;

   // Interrupt status and mask bits
   localparam int IRQ_RX   = 0;
   localparam int IRQ_TX   = 1;
   localparam int IRQ_MS   = 2;
   localparam int IRQ_W    = 3;

   // Trigger tables, six bits per entry, entry 0 lowest
   localparam logic [23:0] RX_LVL_TAB = {6'd28, 6'd24, 6'd16, 6'd8};
   localparam logic [23:0] TX_LVL_TAB = {6'd30, 6'd24, 6'd8, 6'd16};

   // Reset values
   localparam logic [5:0]  LVL_RESET   = 6'd1;
   localparam logic [7:0]  LINE_RESET  = 8'h00;
   localparam logic [7:0]  MODEM_RESET = 8'h00;
   localparam logic [7:0]  FEAT_RESET  = 8'h00;
   localparam logic [15:0] DIV_RESET   = 16'h0001;
   localparam logic [3:0]  CHAR_BASE   = 4'd5;

   // Stop length in half bit times
   localparam logic [2:0]  STOP_ONE    = 3'd2;
   localparam logic [2:0]  STOP_ONEH   = 3'd3;
   localparam logic [2:0]  STOP_TWO    = 3'd4;

   // Character format handed to the serial engines
   typedef struct packed {
      logic [3:0] char_bits;
      logic [2:0] stop_halves;
      logic       par_en;
      logic       par_force;
      logic       par_even;
      logic       par_bit;
      logic       brk;
   } ulfc_fmt_t;

   // Captured AHB address phase
   typedef struct packed {
      logic       hit;
      logic [7:0] addr;
   } ulfc_aph_t;

   // Bus slave states
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WR   = 3'b010,
      BUS_RD   = 3'b100
   } ulfc_bus_t;

endpackage : ulfc_pkg

//--- core/ulfc_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin; output changes when stages two and three agree.
module ulfc_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic pin_i,
   output logic      level_o
);
   import ulfc_pkg::*;

   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Shift chain
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a level once two stages agree
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         level_o <= INIT;
      end else if (s2_r == s3_r) begin
         level_o <= s3_r;
      end
   end

endmodule : ulfc_sync

//--- core/ulfc_trig.sv
// FIFO fill level watcher: crossings of a trigger level.
// Assumes count comes from same-clock FIFO logic.
module ulfc_trig (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic [5:0] count_i,
   input  wire logic [5:0] level_i,
   output logic            up_o,
   output logic            down_o,
   output logic            empty_o
);
   import ulfc_pkg::*;

   logic [5:0] prev_r;
   logic       over_r;

   // Previous count and fill-past-level memory
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_r <= 6'h00;
         over_r <= 1'b0;
      end else begin
         prev_r <= count_i;
         if (count_i > level_i) begin
            over_r <= 1'b1;
         end else if (count_i == 6'h00) begin
            over_r <= 1'b0;
         end
      end
   end

   // Edge events on the level
   assign up_o    = (prev_r < level_i) && (count_i >= level_i);
   assign down_o  = (prev_r >= level_i) && (count_i < level_i);
   assign empty_o = (prev_r != 6'h00) && (count_i == 6'h00) && !over_r;

endmodule : ulfc_trig

//--- verification/uart_line_format_control_tb_top.sv
// Self-checking bench for the line format control block.
// Assumes the bind in the checker file and the remote station model.
module uart_line_format_control_tb_top;
   import ulfc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, nrst_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        tx_serial = 1'b1, auto_rts_n = 1'b1;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [5:0]  rx_count = '0, tx_count = '0, rx_level, tx_level;
   logic [15:0] divisor;
   ulfc_fmt_t   fmt;
   logic        hreadyout, rx_data, loopback, tx_pin, dtr_n, rts_n, irq;
   logic        rx_pin, cts_n, dsr_n, ri_n, cd_n;
   int          err_total = 0, tests_run = 0, cycles = 0;
   // Clock and cycle ceiling
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         end_sim();
      end
   end
   ulfc_core u_ulfc_core (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
      .hreadyout_o(hreadyout), .hresp_o(), .rx_count_i(rx_count),
      .tx_count_i(tx_count), .tx_serial_i(tx_serial),
      .auto_rts_n_i(auto_rts_n), .fmt_o(fmt), .divisor_o(divisor),
      .fifo_en_o(), .dma_mode_o(), .rx_fifo_clr_o(), .tx_fifo_clr_o(),
      .rx_level_o(rx_level), .tx_level_o(tx_level), .rx_data_o(rx_data),
      .loopback_o(loopback), .irda_en_o(), .rx_pin_i(rx_pin),
      .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ring_indicator_in_n_i(ri_n),
      .cd_n_i(cd_n), .tx_pin_o(tx_pin), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
      .out2_n_o(), .irq_o(irq));
   ulfc_remote u_ulfc_remote (.clk_i(clk_i), .tx_line_i(tx_pin),
      .rts_n_i(rts_n), .rx_line_o(rx_pin), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
      .ri_n_o(ri_n), .cd_n_o(cd_n));
   // Verdict and end of run
   task automatic end_sim();
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   // One AHB-Lite single transfer, entered just after an edge
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      @(posedge clk_i);
      while (hreadyout !== 1'b1) @(posedge clk_i);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) @(posedge clk_i);
      r = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, '0, q);
      chk(q, e);
   endtask : rdc
   task automatic t_reset();
      rdc(A_LINE, 0);
      rdc(A_MODEM, 0);
      rdc(A_LEVEL, 32'h0000_0041);
      chk(32'({tx_pin, dtr_n, rts_n, irq}), 32'h0000_000E);
   endtask : t_reset
   task automatic t_trig();
      logic [5:0] rxt [4];
      logic [5:0] txt [4];
      rxt = '{6'd8, 6'd16, 6'd24, 6'd28};
      txt = '{6'd16, 6'd8, 6'd24, 6'd30};
      wr(A_FEAT, 32'h0000_0010);
      for (int i = 0; i < 4; i++) begin
         wr(A_FIFO, {24'h00_0000, i[1:0], i[1:0], 4'h1});
         rdc(A_LEVEL, {18'h0_0000, 2'b10, txt[i], rxt[i]});
         chk(32'(rx_level), 32'(rxt[i]));
      end
      wr(A_FIFO, 0);
      rdc(A_LEVEL, {20'h0_0000, txt[3], rxt[3]});
      rdc(A_FIFO, 0);
      rdc(8'h40, 0);
   endtask : t_trig
   task automatic t_fmt();
      logic [2:0] st;
      for (int i = 0; i < 64; i++) begin
         wr(A_LINE, i);
         rdc(A_LINE, i);
         st = !i[2] ? 3'd2 : (i[1:0] == 2'd0 ? 3'd3 : 3'd4);
         chk(32'(fmt.char_bits), 32'(4'd5 + i[1:0]));
         chk(32'(fmt.stop_halves), 32'(st));
         chk(32'({fmt.par_en, fmt.par_even & i[3], fmt.par_force & i[3]}),
             32'({i[3], i[4] & i[3], i[5] & i[3]}));
         if (i[5] & i[3]) chk(32'(fmt.par_bit), 32'(!i[4]));
      end
   endtask : t_fmt
   task automatic t_brk_div();
      wr(A_LINE, 32'h0000_0043);
      cyc(4);
      chk(32'({tx_pin, u_ulfc_remote.brk_cycles > 0}), 1);
      wr(A_LINE, 0);
      cyc(4);
      chk(32'(tx_pin), 1);
      wr(A_DIVL, 32'h0000_005A);
      rdc(A_DIVL, 0);
      chk(32'(divisor), 1);
      wr(A_LINE, 32'h0000_0080);
      wr(A_DIVL, 32'h0000_005A);
      wr(A_DIVH, 32'h0000_0012);
      rdc(A_DIVH, 32'h0000_0012);
      chk(32'(divisor), 32'h0000_125A);
      wr(A_LINE, 0);
   endtask : t_brk_div
   task automatic t_modem();
      for (int i = 0; i < 4; i++) begin
         wr(A_MODEM, i);
         rdc(A_MODEM, i);
         chk(32'({dtr_n, rts_n}), 32'({!i[0], !i[1]}));
      end
      wr(A_MODEM, 32'h0000_0016);
      tx_serial <= 1'b0;
      cyc(6);
      ahb(1'b0, A_MSTAT, '0, q);
      chk(q & 32'h0000_00F0, 32'h0000_0050);
      chk(32'({rx_data, tx_pin}), 1);
      wr(A_MODEM, 32'h0000_0010);
      ahb(1'b0, A_MSTAT, '0, q);
      chk(q & 32'h0000_00F0, 0);
      tx_serial <= 1'b1;
      wr(A_MODEM, 32'h0000_0040);
      cyc(8);
      chk(32'(rx_data), 0);
      wr(A_MODEM, 32'h0000_0044);
      cyc(8);
      chk(32'(rx_data), 1);
      u_ulfc_remote.set_rx(1'b0);
      cyc(8);
      chk(32'(rx_data), 0);
      u_ulfc_remote.set_rx(1'b1);
      wr(A_MODEM, 0);
   endtask : t_modem
   task automatic t_irq();
      wr(A_FIFO, 32'h0000_0001);
      wr(A_ISTAT, 32'h0000_000F);
      wr(A_IMASK, 32'h0000_0003);
      rx_count <= 6'd7;
      cyc(4);
      chk(32'(irq), 0);
      rx_count <= 6'd8;
      cyc(4);
      chk(32'(irq), 1);
      rdc(A_ISTAT, 1);
      wr(A_ISTAT, 1);
      rdc(A_ISTAT, 0);
      tx_count <= 6'd20;
      cyc(4);
      tx_count <= 6'd15;
      cyc(4);
      rdc(A_ISTAT, 2);
      wr(A_IMASK, 0);
      cyc(2);
      chk(32'(irq), 0);
      wr(A_ISTAT, 2);
      tx_count <= 6'd0;
      cyc(4);
      rdc(A_ISTAT, 0);
      tx_count <= 6'd5;
      cyc(4);
      tx_count <= 6'd0;
      cyc(4);
      rdc(A_ISTAT, 2);
   endtask : t_irq
   // Reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_trig();
      t_fmt();
      t_brk_div();
      t_modem();
      t_irq();
      end_sim();
   end
endmodule : uart_line_format_control_tb_top

//--- verification/ulfc_core_properties.sv
// Concurrent checks on the line format control block ports.
// Assumes hready_i is fed back from hreadyout_o by the bench.
module ulfc_core_properties
   import ulfc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic        hresp_o,
   input wire logic [5:0]  rx_count_i,
   input wire logic [5:0]  tx_count_i,
   input wire ulfc_fmt_t   fmt_o,
   input wire logic [15:0] divisor_o,
   input wire logic [5:0]  rx_level_o,
   input wire logic [5:0]  tx_level_o,
   input wire logic        tx_pin_o,
   input wire logic        dtr_n_o,
   input wire logic        rts_n_o,
   input wire logic        loopback_o,
   input wire logic        irq_o
);
   localparam logic [5:0] RXT [4] = '{6'd8, 6'd16, 6'd24, 6'd28};
   localparam logic [5:0] TXT [4] = '{6'd16, 6'd8, 6'd24, 6'd30};
   logic       aw_r, wv_r;
   logic [7:0] aa_r, wa_r, wd_r, line_s, feat_s, msk_s;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Write capture: wv_r marks the cycle after a write data edge
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_r <= 1'b0;
         wv_r <= 1'b0;
         aa_r <= 8'h00;
         wa_r <= 8'h00;
         wd_r <= 8'h00;
      end else begin
         wv_r <= aw_r && hready_i;
         if (aw_r && hready_i) begin
            wa_r <= aa_r;
            wd_r <= hwdata_i[7:0];
         end
         if (hready_i) begin
            aw_r <= hsel_i && htrans_i[1] && hwrite_i && !(|haddr_i[31:8]);
            aa_r <= haddr_i[7:0];
         end
      end
   end
   // Shadow copies of the registers that qualify other checks
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         line_s <= 8'h00;
         feat_s <= 8'h00;
         msk_s <= 8'h00;
      end else if (wv_r) begin
         if (wa_r == A_LINE) line_s <= wd_r;
         if (wa_r == A_FEAT) feat_s <= wd_r;
         if (wa_r == A_IMASK) msk_s <= wd_r;
      end
   end
   // Write events and fill level crossings
   sequence line_wr; wv_r && wa_r == A_LINE; endsequence
   sequence mdm_wr; wv_r && wa_r == A_MODEM && !wd_r[MC_LOOP]; endsequence
   sequence fifo_wr; wv_r && wa_r == A_FIFO && wd_r[FC_EN]; endsequence
   sequence rx_up;
      rx_count_i >= rx_level_o && $past(rx_count_i) < rx_level_o;
   endsequence
   sequence tx_dn;
      tx_count_i < tx_level_o && $past(tx_count_i) >= tx_level_o;
   endsequence
   AST_CHAR: assert property (line_wr
      |=> fmt_o.char_bits == 4'd5 + wd_r[1:0])
      else $error("character length differs from line write");
   AST_STOP: assert property (line_wr |=> fmt_o.stop_halves ==
      (!wd_r[LC_STOP] ? STOP_ONE : (wd_r[1:0] == 2'd0 ? STOP_ONEH : STOP_TWO)))
      else $error("stop length differs from line write");
   AST_PAR: assert property (line_wr |=>
      fmt_o.par_en == wd_r[LC_PEN] && (!wd_r[LC_PEN] ||
      (fmt_o.par_even == wd_r[LC_EVEN]
      && fmt_o.par_force == wd_r[LC_FORCE])))
      else $error("parity fields differ from line write");
   AST_BRK: assert property (fmt_o.brk && $past(fmt_o.brk) && !loopback_o
      |-> !tx_pin_o) else $error("serial output not low during break");
   AST_DIV: assert property (wv_r && wa_r == A_DIVL && line_s[LC_DLAB]
      |-> ##[0:1] divisor_o[7:0] == wd_r)
      else $error("divisor low not written");
   AST_DTR: assert property (mdm_wr |-> ##[0:2] dtr_n_o == !wd_r[MC_DTR])
      else $error("terminal ready pin differs from modem bit");
   AST_RTS: assert property (mdm_wr ##0 !feat_s[EF_ARTS]
      |-> ##[0:2] rts_n_o == !wd_r[MC_RTS]) else $error("request pin wrong");
   AST_RXLVL: assert property (fifo_wr
      |-> ##[0:1] rx_level_o == RXT[wd_r[7:6]])
      else $error("receive trigger level wrong");
   AST_TXLVL: assert property (fifo_wr ##0 feat_s[EF_ENH]
      |-> ##[0:1] tx_level_o == TXT[wd_r[5:4]]) else $error("tx level wrong");
   AST_RXIRQ: assert property (rx_up ##0 msk_s[IRQ_RX] |-> ##[1:4] irq_o)
      else $error("no interrupt on receive level crossing");
   AST_TXIRQ: assert property (tx_dn ##0 msk_s[IRQ_TX] |-> ##[1:4] irq_o)
      else $error("no interrupt on transmit level crossing");
   AST_OKAY: assert property (hresp_o == 1'b0)
      else $error("bus response not okay");
endmodule : ulfc_core_properties

bind ulfc_core ulfc_core_properties u_ulfc_core_properties (
   .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
   .hready_i(hready_i), .hresp_o(hresp_o), .rx_count_i(rx_count_i),
   .tx_count_i(tx_count_i), .fmt_o(fmt_o), .divisor_o(divisor_o),
   .rx_level_o(rx_level_o), .tx_level_o(tx_level_o), .tx_pin_o(tx_pin_o),
   .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .loopback_o(loopback_o),
   .irq_o(irq_o));

//--- verification/ulfc_remote.sv
// Remote station on the serial line and modem lines.
// Assumes the bench clock; receive line idles at mark.
module ulfc_remote (
   input  wire logic clk_i,
   input  wire logic tx_line_i,
   input  wire logic rts_n_i,
   output logic      rx_line_o,
   output logic      cts_n_o,
   output logic      dsr_n_o,
   output logic      ri_n_o,
   output logic      cd_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int brk_cycles = 0;
   // Idle line and inactive modem lines
   initial begin
      rx_line_o = 1'b1;
      cts_n_o = 1'b1;
      dsr_n_o = 1'b1;
      ri_n_o = 1'b1;
      cd_n_o = 1'b1;
   end
   // Flow partner grants clear as soon as asked
   always @(posedge clk_i) cts_n_o <= rts_n_i;
   always @(posedge clk_i) if (!tx_line_i) brk_cycles <= brk_cycles + 1;
   // Change the receive line after an edge
   task automatic set_rx(input logic v);
      @(posedge clk_i);
      rx_line_o <= v;
   endtask : set_rx
endmodule : ulfc_remote
